//--- core/dscp_device.sv
// Summary of operation
// - 24-bit MSB first: command, address, data
// - Shift data in on falling clock edges
// - Execute command when frame select rises
// - Short frame still executes partial contents
// - Host sends exactly 24 clocks per frame
// - Host keeps frame select high 20 ns
// - Address 0 to 15 picks channel
// - Commands reach one, some or all channels
// - Codes 0000 and 1111 do nothing
// - 0001 writes input register, strobe-dependent
// - 0010 copies inputs to outputs by mask
// - 0011 writes output register directly
// - 0100 power state, 0101 strobe mask
// - 0110 soft reset, 0111 reference setup
// - 1000 chain enable, 1001 readback select
// - 1010 all inputs, 1011 all both
// - Codes 1100 to 1110 ignored
// - Strobe low, select high: outputs load
// - Reference on after reset, writable off
// - Reset puts outputs in known state
// - Update data bits select channels
// - Chain enable bit 0: standalone default
// - Readback shifts out during next frame
//
// Purpose: converter end of the serial command port
// Assumes: link pins sampled by pclk; sclk slower than pclk/4
// Notes: output codes are flat 256-bit buses, channel n at [16n+:16]
//
// Local design decisions: the APB register port and the placing of the registers.
`default_nettype none
module dscp_device
	import dscp_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Link
	dscp_if.device lnk,
	// Converter state
	output logic [NUM_CH*16-1:0] dac_code,
	output logic [NUM_CH*2-1:0] power_mode,
	output logic ref_enable,
	output logic chain_mode,
	output logic frame_done
);
	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic sync_s, sclk_s, sdi_s, strobe_n_s;
	dscp_sync2 u_sync (.pclk(pclk), .presetn(presetn),
		.d(lnk.sync_n), .q(sync_s));
	dscp_sync2 u_sclk (.pclk(pclk), .presetn(presetn),
		.d(lnk.sclk), .q(sclk_s));
	dscp_sync2 u_sdi (.pclk(pclk), .presetn(presetn),
		.d(lnk.sdi), .q(sdi_s));
	dscp_sync2 u_strobe (.pclk(pclk), .presetn(presetn),
		.d(lnk.load_outputs_n), .q(strobe_n_s));

	// Delayed copies reset to the idle pin levels: no false edge after reset
	logic sync_d_ff, sclk_d_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_d_ff <= 1'b1;
			sclk_d_ff <= 1'b1;
		end else begin
			sync_d_ff <= sync_s;
			sclk_d_ff <= sclk_s;
		end
	end
	wire sclk_fall = sclk_d_ff & ~sclk_s;
	wire sclk_rise = ~sclk_d_ff & sclk_s;
	wire sync_rise = ~sync_d_ff & sync_s;
	wire sync_fall = sync_d_ff & ~sync_s;

	// ----------------------------------------------------------------
	// Shift register
	// ----------------------------------------------------------------
	logic [FRAME_BITS-1:0] shift_ff;
	logic [FRAME_BITS-1:0] rdbk_ff;
	logic sdo_ff;
	wire shift_en = sclk_fall & ~sync_s;
	wire [FRAME_BITS-1:0] nxt_shift = {shift_ff[FRAME_BITS-2:0], sdi_s};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shift_ff <= '0;
		end else if (sync_fall) begin
			shift_ff <= '0;
		end else if (shift_en) begin
			shift_ff <= nxt_shift;
		end
	end

	wire [3:0] command_code = shift_ff[CMD_MSB:CMD_LSB];
	wire [3:0] channel_address = shift_ff[ADDR_MSB:ADDR_LSB];
	wire [15:0] data_word = shift_ff[DATA_MSB:0];

	// ----------------------------------------------------------------
	// Channel registers
	// ----------------------------------------------------------------
	logic [15:0] in_ff [NUM_CH];
	logic [15:0] out_ff [NUM_CH];
	logic [15:0] mask_ff;
	logic [NUM_CH*2-1:0] pwr_ff;
	logic ref_ff, chain_ff, rd_pend_ff;
	logic [3:0] rd_sel_ff;

	// Executes on select rise, even for short frames
	wire exec = sync_rise;
	wire do_rst = exec && command_code == CMD_SWRST;
	wire hw_load = sync_s & ~strobe_n_s;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NUM_CH; i++) begin
				in_ff[i] <= CH_RESET_VAL;
				out_ff[i] <= CH_RESET_VAL;
			end
		end else if (do_rst) begin
			for (int i = 0; i < NUM_CH; i++) begin
				in_ff[i] <= CH_RESET_VAL;
				out_ff[i] <= CH_RESET_VAL;
			end
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (exec) begin
					unique case (command_code)
					CMD_WR_IN: if (channel_address == 4'(i))
						in_ff[i] <= data_word;
					CMD_UPD: if (data_word[i])
						out_ff[i] <= in_ff[i];
					CMD_WR_UPD: if (channel_address == 4'(i)) begin
						in_ff[i] <= data_word;
						out_ff[i] <= data_word;
					end
					CMD_ALL_IN: in_ff[i] <= data_word;
					CMD_ALL_BOTH: begin
						in_ff[i] <= data_word;
						out_ff[i] <= data_word;
					end
					default: ;
					endcase
				end else if (hw_load && !mask_ff[i]) begin
					out_ff[i] <= in_ff[i];
				end
			end
		end
	end

	// Mode registers; reserved codes fall to default and hold
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_ff <= 16'h0000;
			pwr_ff <= '0;
			ref_ff <= REF_RESET_VAL;
			chain_ff <= CHAIN_RESET_VAL;
			rd_sel_ff <= 4'h0;
		end else if (do_rst) begin
			mask_ff <= 16'h0000;
			pwr_ff <= '0;
			ref_ff <= REF_RESET_VAL;
			chain_ff <= CHAIN_RESET_VAL;
			rd_sel_ff <= 4'h0;
		end else if (exec) begin
			unique case (command_code)
			CMD_PWR: begin
				if (channel_address[3])
					pwr_ff[31:16] <= data_word;
				else
					pwr_ff[15:0] <= data_word;
			end
			CMD_MASK: mask_ff <= data_word;
			CMD_REF: ref_ff <= ~data_word[0];
			CMD_CHAIN: chain_ff <= data_word[0];
			CMD_RDBK: rd_sel_ff <= channel_address;
			default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Serial output: readback and chain
	// ----------------------------------------------------------------
	// Readback armed by one frame, consumed by the next
	wire [FRAME_BITS-1:0] rdbk_load = {4'h0, rd_sel_ff, in_ff[rd_sel_ff]};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_pend_ff <= 1'b0;
			rdbk_ff <= '0;
			sdo_ff <= 1'b0;
			frame_done <= 1'b0;
		end else begin
			frame_done <= exec;
			if (exec)
				rd_pend_ff <= command_code == CMD_RDBK && !do_rst;
			if (sync_fall) begin
				rdbk_ff <= rdbk_load;
				// First bit must stand before the host's first sample
				if (rd_pend_ff)
					sdo_ff <= rdbk_load[FRAME_BITS-1];
				else if (chain_ff)
					sdo_ff <= 1'b0;
			end else if (shift_en)
				rdbk_ff <= {rdbk_ff[FRAME_BITS-2:0], 1'b0};
			// Output moves on the rising edge, valid at the falling one
			if (sclk_rise && !sync_s) begin
				if (rd_pend_ff)
					sdo_ff <= rdbk_ff[FRAME_BITS-1];
				else if (chain_ff)
					sdo_ff <= shift_ff[FRAME_BITS-1];
			end
		end
	end
	assign lnk.sdo = sdo_ff;

	always_comb begin
		for (int i = 0; i < NUM_CH; i++)
			dac_code[i*16 +: 16] = out_ff[i];
	end
	assign power_mode = pwr_ff;
	assign ref_enable = ref_ff;
	assign chain_mode = chain_ff;
endmodule
`default_nettype wire

//--- core/dscp_pkg.sv
// Purpose: shared constants for the serial command port, both ends
// Assumes: 24-bit frames, MSB first, sixteen channels
// Notes: timing counts derived from the 100 MHz pclk
`default_nettype none
package dscp_pkg;
	localparam int FRAME_BITS = 24;
	localparam int CMD_MSB = 23;
	localparam int CMD_LSB = 20;
	localparam int ADDR_MSB = 19;
	localparam int ADDR_LSB = 16;
	localparam int DATA_MSB = 15;
	localparam int NUM_CH = 16;
	localparam int CLK_NS = 10;
	localparam int SYNC_HIGH_NS = 20;
	localparam int SYNC_HIGH_CYC = (SYNC_HIGH_NS + CLK_NS - 1) / CLK_NS;
	localparam int SCLK_HALF_CYC = 4;
	localparam logic [15:0] CH_RESET_VAL = 16'h0000;
	localparam logic REF_RESET_VAL = 1'b1;
	localparam logic CHAIN_RESET_VAL = 1'b0;
	localparam logic [3:0] CMD_NOP = 4'h0;
	localparam logic [3:0] CMD_WR_IN = 4'h1;
	localparam logic [3:0] CMD_UPD = 4'h2;
	localparam logic [3:0] CMD_WR_UPD = 4'h3;
	localparam logic [3:0] CMD_PWR = 4'h4;
	localparam logic [3:0] CMD_MASK = 4'h5;
	localparam logic [3:0] CMD_SWRST = 4'h6;
	localparam logic [3:0] CMD_REF = 4'h7;
	localparam logic [3:0] CMD_CHAIN = 4'h8;
	localparam logic [3:0] CMD_RDBK = 4'h9;
	localparam logic [3:0] CMD_ALL_IN = 4'hA;
	localparam logic [3:0] CMD_ALL_BOTH = 4'hB;
	localparam logic [3:0] CMD_NOP_CHAIN = 4'hF;
	// APB register offsets of the host controller
	localparam logic [11:0] REG_TX = 12'h000;
	localparam logic [11:0] REG_STATUS = 12'h004;
	localparam logic [11:0] REG_RX = 12'h008;
	localparam logic [11:0] REG_LOAD = 12'h00C;
	localparam int ST_BUSY_BIT = 0;
endpackage
`default_nettype wire

//--- core/dscp_if.sv
// Purpose: serial link between host controller and converter port
// Assumes: plain wires, no clocking block
// Notes: serial output is only valid while frame select is low
`default_nettype none
interface dscp_if;
	logic sync_n;
	logic sclk;
	logic sdi;
	logic sdo;
	logic load_outputs_n;
	modport device (input sync_n, input sclk, input sdi,
		input load_outputs_n, output sdo);
	modport host (output sync_n, output sclk, output sdi,
		output load_outputs_n, input sdo);
endinterface
`default_nettype wire

//--- core/dscp_sync2.sv
// Purpose: two-flop synchroniser for one pin
// Assumes: d is asynchronous to clk
// Notes: the first stage is read only by the second
`default_nettype none
module dscp_sync2 (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Data
	input wire logic d,
	output logic q
);
	logic meta_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_ff <= 1'b1;
			q <= 1'b1;
		end else begin
			meta_ff <= d;
			q <= meta_ff;
		end
	end
endmodule
`default_nettype wire

//--- core/dscp_host.sv
// Purpose: APB-controlled host end that sends 24-bit frames
// Assumes: pclk 100 MHz; sclk made by divider
// Notes: software writes TX to start a frame, polls STATUS
`default_nettype none
module dscp_host
	import dscp_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Link
	dscp_if.host lnk
);
	typedef enum logic [1:0] {
		DH_IDLE = 2'b00, DH_HIGH = 2'b01, DH_LOW = 2'b11, DH_GAP = 2'b10
	} dh_state_t;
	dh_state_t st_ff;
	logic [23:0] tx_ff, rx_ff;
	logic [4:0] bits_ff;
	logic [2:0] div_ff;
	logic sclk_ff, sync_ff, strobe_n_ff, sdo_s;

	dscp_sync2 u_sdo (.pclk(pclk), .presetn(presetn),
		.d(lnk.sdo), .q(sdo_s));

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	wire acc = psel & penable;
	wire wr_tx = acc & pwrite & (paddr == REG_TX) & (st_ff == DH_IDLE);
	wire wr_ld = acc & pwrite & (paddr == REG_LOAD);
	wire hit = paddr == REG_TX || paddr == REG_STATUS ||
		paddr == REG_RX || paddr == REG_LOAD;
	wire busy = st_ff != DH_IDLE;
	assign pready = 1'b1;
	assign pslverr = acc & ~hit;
	always_comb begin
		prdata = 32'h0000_0000;
		if (paddr == REG_STATUS)
			prdata[ST_BUSY_BIT] = busy;
		else if (paddr == REG_RX)
			prdata[23:0] = rx_ff;
		else if (paddr == REG_LOAD)
			prdata[0] = ~strobe_n_ff;
	end

	wire tick = div_ff == 3'(SCLK_HALF_CYC - 1);

	// ----------------------------------------------------------------
	// Frame engine: 24 falls, then select high for the gap
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= DH_IDLE;
			tx_ff <= '0;
			rx_ff <= '0;
			bits_ff <= 5'h00;
			div_ff <= 3'h0;
			sclk_ff <= 1'b1;
			sync_ff <= 1'b1;
			strobe_n_ff <= 1'b1;
		end else begin
			// Strobe only while select is high
			if (wr_ld)
				strobe_n_ff <= ~(pwdata[0] & ~busy);
			div_ff <= tick ? 3'h0 : div_ff + 3'h1;
			unique case (st_ff)
			DH_IDLE: if (wr_tx) begin
				tx_ff <= pwdata[23:0];
				sync_ff <= 1'b0;
				strobe_n_ff <= 1'b1;
				bits_ff <= 5'h00;
				div_ff <= 3'h0;
				st_ff <= DH_HIGH;
			end
			DH_HIGH: if (tick) begin
				sclk_ff <= 1'b0;
				st_ff <= DH_LOW;
			end
			DH_LOW: if (tick) begin
				sclk_ff <= 1'b1;
				rx_ff <= {rx_ff[22:0], sdo_s};
				tx_ff <= {tx_ff[22:0], 1'b0};
				bits_ff <= bits_ff + 5'h01;
				if (bits_ff == 5'(FRAME_BITS - 1)) begin
					sync_ff <= 1'b1;
					st_ff <= DH_GAP;
				end else begin
					st_ff <= DH_HIGH;
				end
			end
			DH_GAP: if (div_ff == 3'(SYNC_HIGH_CYC))
				st_ff <= DH_IDLE;
			endcase
		end
	end

	assign lnk.sclk = sclk_ff;
	assign lnk.sync_n = sync_ff;
	assign lnk.sdi = tx_ff[23];
	assign lnk.load_outputs_n = strobe_n_ff;
endmodule
`default_nettype wire

//--- dv/dscp_monitor.sv
// Purpose: link checks between host and converter ends
// Assumes: plain interface signals, one pclk domain
// Notes: host timing comes from its fixed clock divider
`default_nettype none
module dscp_monitor (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Link
	input wire logic sync_n,
	input wire logic sclk,
	input wire logic sdi,
	input wire logic sdo,
	input wire logic load_outputs_n
);
	// ----------------------------------------
	// Falling clock edges within a frame
	// ----------------------------------------
	logic [4:0] fall_cnt_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			fall_cnt_ff <= 5'h00;
		else if ($fell(sync_n))
			fall_cnt_ff <= 5'h00;
		else if (!sync_n && $fell(sclk))
			fall_cnt_ff <= fall_cnt_ff + 5'h01;
	end
	default clocking dcb @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_frame_edge_count: assert property (
		$rose(sync_n) |-> fall_cnt_ff == 5'h18) else $error("edge count");
	chk_idle_clock_high: assert property (
		sync_n |-> sclk) else $error("clock low outside frame");
	chk_select_gap: assert property (
		$rose(sync_n) |-> sync_n[*2]) else $error("select gap short");
	chk_clock_low_half: assert property (
		$fell(sclk) |-> !sclk[*4]) else $error("clock low half short");
	chk_data_on_rise: assert property (
		!sync_n && !$fell(sync_n) && $changed(sdi) |-> $rose(sclk))
		else $error("data moved off the rising edge");
	chk_strobe_when_idle: assert property (
		!load_outputs_n |-> sync_n) else $error("strobe inside frame");
	chk_sdo_high_half: assert property (
		!sync_n && $changed(sdo) |-> sclk) else $error("sdo moved late");
	chk_frame_min_len: assert property (
		$fell(sync_n) |-> !sync_n[*8]) else $error("frame too short");
endmodule
`default_nettype wire

//--- dv/dac_serial_command_port_tb.sv
// Purpose: end-to-end bench, APB host driving the converter port
// Assumes: host makes the serial clock; reset held 12 cycles
// Notes: a converter model predicts the state after each frame
`default_nettype none
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin \
	error_cnt++; $display("CHECK FAILED %s exp=%h got=%h", nm, e, s); \
	end end
module dac_serial_command_port_tb
	import dscp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, r, seed, pw_m;
	logic [255:0] dac_code;
	logic [31:0] power_mode;
	logic ref_enable, chain_mode, frame_done, ref_m, chain_m;
	logic rb_arm, rb_due;
	logic [15:0] in_m [16];
	logic [15:0] out_m [16];
	logic [15:0] mask_m;
	logic [3:0] rb_sel;
	logic [23:0] rb_exp;
	logic [289:0] exp_v;
	logic [289:0] exp_q [$];
	int error_cnt, n_checks;
	wire [289:0] seen = {dac_code, power_mode, ref_enable, chain_mode};
	dscp_if lnk_if ();
	dscp_host dscp_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.lnk(lnk_if.host));
	dscp_device dscp_device_inst (.pclk(pclk), .presetn(presetn),
		.lnk(lnk_if.device), .dac_code(dac_code), .power_mode(power_mode),
		.ref_enable(ref_enable), .chain_mode(chain_mode),
		.frame_done(frame_done));
	dscp_monitor dscp_monitor_inst (.pclk(pclk), .presetn(presetn),
		.sync_n(lnk_if.sync_n), .sclk(lnk_if.sclk), .sdi(lnk_if.sdi),
		.sdo(lnk_if.sdo), .load_outputs_n(lnk_if.load_outputs_n));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [289:0] state_v();
		logic [255:0] c;
		for (int i = 0; i < 16; i++)
			c[16*i+:16] = out_m[i];
		return {c, pw_m, ref_m, chain_m};
	endfunction
	task automatic clr_model();
		for (int i = 0; i < 16; i++) begin
			in_m[i] = CH_RESET_VAL;
			out_m[i] = CH_RESET_VAL;
		end
		pw_m = 32'h0;
		mask_m = 16'h0;
		ref_m = REF_RESET_VAL;
		chain_m = CHAIN_RESET_VAL;
	endtask
	task automatic model(input logic [23:0] f);
		logic [15:0] d;
		d = f[15:0];
		case (f[23:20])
		CMD_WR_IN: in_m[f[19:16]] = d;
		CMD_WR_UPD: begin
			in_m[f[19:16]] = d;
			out_m[f[19:16]] = d;
		end
		CMD_PWR: pw_m[16*f[19]+:16] = d;
		CMD_MASK: mask_m = d;
		CMD_SWRST: clr_model();
		CMD_REF: ref_m = !d[0];
		CMD_CHAIN: chain_m = d[0];
		CMD_RDBK: rb_sel = f[19:16];
		CMD_UPD, CMD_ALL_IN, CMD_ALL_BOTH: for (int i = 0; i < 16; i++) begin
			if (f[23:20] != CMD_UPD)
				in_m[i] = d;
			if (f[23:20] == CMD_ALL_BOTH || (f[23:20] == CMD_UPD && d[i]))
				out_m[i] = in_m[i];
		end
		default: ;
		endcase
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic idle();
		do apb(1'b0, REG_STATUS, 32'h0); while (rd[ST_BUSY_BIT] !== 1'b0);
		if (rb_due) begin
			apb(1'b0, REG_RX, 32'h0);
			`CHK("readback", rb_exp, rd[23:0])
		end
		rb_due = 1'b0;
	endtask
	task automatic send(input logic [23:0] f);
		idle();
		rb_due = rb_arm && !chain_m;
		rb_exp = {4'h0, rb_sel, in_m[rb_sel]};
		rb_arm = (f[23:20] == CMD_RDBK);
		apb(1'b1, REG_TX, {8'h00, f});
		model(f);
		exp_q.push_back(state_v());
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// ----------------------------------------
	// Clock, watchdog, result watcher, stimulus
	// ----------------------------------------
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	initial begin
		repeat (60000) @(posedge pclk);
		error_cnt++;
		$display("watchdog expired");
		test_done();
	end
	initial forever begin
		@(posedge pclk);
		if (frame_done === 1'b1) begin
			exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : ~seen;
			`CHK("state", exp_v, seen)
		end
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{error_cnt, n_checks, rb_arm, rb_due, rb_sel} = '0;
		seed = 32'h30;
		clr_model();
		repeat (12) @(posedge pclk);
		`CHK("reset", state_v(), seen)
		presetn <= 1'b1;
		// Every code twice; via the model
		for (int i = 0; i < 32; i++) begin
			r = xs();
			send({i[3:0], r[19:0]});
			if (i == 9) begin
				apb(1'b0, REG_STATUS, 32'h0);
				`CHK("busy", 1'b1, rd[ST_BUSY_BIT])
				// Refused while busy: an extra frame would find no note
				apb(1'b1, REG_TX, {8'h00, CMD_WR_UPD, r[23:4]});
			end
		end
		$display("test commands done");
		r = xs();
		send({CMD_MASK, 4'h0, r[15:0]});
		send({CMD_WR_IN, 4'h3, r[31:16]});
		send({CMD_WR_IN, 4'hC, ~r[15:0]});
		// Standalone readback of a known word, carried by a NOP frame
		send({CMD_CHAIN, 20'h00000});
		send({CMD_RDBK, 4'hC, 16'h0000});
		send({CMD_NOP, 20'h00000});
		idle();
		repeat (10) @(posedge pclk);
		apb(1'b1, REG_LOAD, 32'h1);
		apb(1'b0, REG_LOAD, 32'h0);
		`CHK("strobe read", 1'b1, rd[0])
		repeat (8) @(posedge pclk);
		for (int i = 0; i < 16; i++)
			if (!mask_m[i])
				out_m[i] = in_m[i];
		`CHK("strobe", state_v(), seen)
		apb(1'b1, REG_LOAD, 32'h0);
		apb(1'b0, 12'h010, 32'h0);
		`CHK("unmapped", 1'b1, err)
		`CHK("drained", 0, exp_q.size())
		$display("test strobe done");
		test_done();
	end
endmodule
`default_nettype wire
